// File: ccsm_top.sv
`timescale 1ns/1ps
`default_nettype none
module ccsm_top (
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   input  wire logic        RESET_PIN_IN,
   output var  logic        RESET_PIN_OUT,
   output var  logic        RESET_PIN_OE_N,
   input  wire logic        LOW_SUPPLY_IN,
   input  wire logic        WDG_UNDERFLOW,
   input  wire logic        ILLEGAL_OPCODE,
   input  wire logic        HALT_ACTIVE,
   input  wire logic        OPT_SLOW_START,
   input  wire logic        RC_CLK_IN,
   input  wire logic        SLOW_CLK_IN,
   output var  logic        CORE_RESET_N,
   output var  logic        VECTOR_FETCH,
   output var  logic [15:0] VECTOR_ADDR,
   output var  logic        OSC_TICK,
   output var  logic        OSC_SEL_SLOW,
   output var  logic        RC_ENABLE,
   output var  logic        SLOW_ENABLE,
   output var  logic        PIN_IS_PORT
);

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   ccsm_pkg::ccsm_pins_t pins_raw;
   ccsm_pkg::ccsm_pins_t pins;

   assign pins_raw.pin_low    = ~RESET_PIN_IN;
   assign pins_raw.low_supply = LOW_SUPPLY_IN;
   assign pins_raw.rc_clk     = RC_CLK_IN;
   assign pins_raw.slow_clk   = SLOW_CLK_IN;

   ccsm_sync u_sync (
      .clk   (MCLK),
      .rst_n (RST_N),
      .din   (pins_raw),
      .dout  (pins)
   );

   logic rc_prev_q;
   logic slow_prev_q;
   logic rc_rise;
   logic slow_rise;

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         rc_prev_q   <= 1'b0;
         slow_prev_q <= 1'b0;
      end else begin
         rc_prev_q   <= pins.rc_clk;
         slow_prev_q <= pins.slow_clk;
      end
   end

   assign rc_rise   = pins.rc_clk & ~rc_prev_q;
   assign slow_rise = pins.slow_clk & ~slow_prev_q;

   // ----------------------------------------
   // Shared state
   // ----------------------------------------
   ccsm_pkg::ccsm_seq_t seq_q;
   ccsm_pkg::ccsm_osc_t osc_q;
   logic       clr;
   logic       port_mode;
   logic [7:0] key_low_q;
   logic [7:0] key_high_q;
   logic       src_sel_q;

   assign clr       = !RST_N || (seq_q == ccsm_pkg::SEQ_ACTIVE);
   assign port_mode = (key_low_q == ccsm_pkg::KEY_LOW_PORT) &&
                      (key_high_q == ccsm_pkg::KEY_HIGH_PORT);

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   logic        acc;
   logic        wr;
   logic [11:0] idx;
   logic        hit;
   logic [7:0]  rd;

   assign acc = PSEL && PENABLE && !PREADY;
   assign wr  = PSEL && PENABLE && PREADY && PWRITE && hit;
   assign idx = {2'h0, PADDR[11:2]};

   logic [1:0] main_ctrl_q;
   logic [7:0] trim_high_q;
   logic [1:0] trim_low_q;
   logic       lsr_flag_q;
   logic [2:0] div_code_q;
   logic [1:0] thresh_q;
   logic       slow_flag_q;
   logic       fast_flag_q;
   logic       key_low_wr_q;
   logic       key_high_wr_q;

   always_comb begin
      hit = (PADDR[1:0] == 2'h0);
      rd  = 8'h00;
      case (idx)
         ccsm_pkg::IDX_MAIN_CLOCK_CTRL: rd = {6'h00, main_ctrl_q};
         ccsm_pkg::IDX_RC_TRIM_HIGH:    rd = trim_high_q;
         ccsm_pkg::IDX_INTEGRITY:       rd = {1'b0, trim_low_q, 2'h0, lsr_flag_q, 2'h0};
         ccsm_pkg::IDX_RC_DIV_THRESH:   rd = {div_code_q, 3'h0, thresh_q};
         ccsm_pkg::IDX_OSC_SWITCH:      rd = {4'h0, slow_flag_q, fast_flag_q,
                                              1'b0, src_sel_q};
         ccsm_pkg::IDX_PIN_KEY_LOW:     rd = key_low_q;
         ccsm_pkg::IDX_PIN_KEY_HIGH:    rd = key_high_q;
         default:                       hit = 1'b0;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= acc;
         PSLVERR <= acc && !hit;
         if (acc && !PWRITE && hit) begin
            PRDATA <= {24'h00_0000, rd};
         end else if (acc) begin
            PRDATA <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------
   // Clock registers
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (clr) begin
         main_ctrl_q <= ccsm_pkg::RST_MAIN_CLOCK_CTRL[1:0];
         trim_high_q <= ccsm_pkg::RST_RC_TRIM_HIGH;
         trim_low_q  <= ccsm_pkg::RST_TRIM_LOW;
      end else if (wr) begin
         if (idx == ccsm_pkg::IDX_MAIN_CLOCK_CTRL) begin
            main_ctrl_q <= PWDATA[1:0];
         end
         if (idx == ccsm_pkg::IDX_RC_TRIM_HIGH) begin
            trim_high_q <= PWDATA[7:0];
         end
         if (idx == ccsm_pkg::IDX_INTEGRITY) begin
            trim_low_q <= PWDATA[6:5];
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (clr) begin
         div_code_q <= ccsm_pkg::RST_DIV_CODE;
         thresh_q   <= ccsm_pkg::RST_THRESHOLD;
      end else if (wr && idx == ccsm_pkg::IDX_RC_DIV_THRESH) begin
         div_code_q <= PWDATA[ccsm_pkg::DIV_MSB:ccsm_pkg::DIV_LSB];
         thresh_q   <= PWDATA[1:0];
      end
   end

   always_ff @(posedge MCLK) begin
      if (clr) begin
         src_sel_q <= 1'b1;
      end else if (wr && idx == ccsm_pkg::IDX_OSC_SWITCH) begin
         src_sel_q <= PWDATA[ccsm_pkg::SRC_SEL_BIT];
      end
   end

   // ----------------------------------------
   // Pin function keys
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (clr) begin
         key_low_q     <= ccsm_pkg::RST_PIN_KEY;
         key_high_q    <= ccsm_pkg::RST_PIN_KEY;
         key_low_wr_q  <= 1'b0;
         key_high_wr_q <= 1'b0;
      end else if (wr) begin
         if (idx == ccsm_pkg::IDX_PIN_KEY_LOW && !key_low_wr_q) begin
            key_low_q    <= PWDATA[7:0];
            key_low_wr_q <= 1'b1;
         end
         if (idx == ccsm_pkg::IDX_PIN_KEY_HIGH && !key_high_wr_q) begin
            key_high_q    <= PWDATA[7:0];
            key_high_wr_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Oscillator switch
   // ----------------------------------------
   logic [3:0] edge_cnt_q;

   always_ff @(posedge MCLK) begin
      if (clr) begin
         osc_q       <= ccsm_pkg::OSC_SLOW;
         slow_flag_q <= 1'b1;
         fast_flag_q <= 1'b0;
         edge_cnt_q  <= 4'h0;
      end else begin
         case (osc_q)
            ccsm_pkg::OSC_RC: begin
               if (src_sel_q) begin
                  osc_q       <= ccsm_pkg::OSC_TO_SLOW;
                  fast_flag_q <= 1'b0;
                  edge_cnt_q  <= 4'h0;
               end
            end
            ccsm_pkg::OSC_TO_SLOW: begin
               if (slow_rise) begin
                  if (edge_cnt_q == ccsm_pkg::TO_SLOW_EDGES) begin
                     osc_q <= ccsm_pkg::OSC_SLOW;
                  end else begin
                     edge_cnt_q <= edge_cnt_q + 4'h1;
                  end
                  if (edge_cnt_q == ccsm_pkg::TO_SLOW_EDGES - 4'h1) begin
                     slow_flag_q <= 1'b1;
                  end
               end
            end
            ccsm_pkg::OSC_SLOW: begin
               if (!src_sel_q) begin
                  osc_q      <= ccsm_pkg::OSC_TO_RC;
                  edge_cnt_q <= 4'h0;
               end
            end
            ccsm_pkg::OSC_TO_RC: begin
               if (rc_rise) begin
                  if (edge_cnt_q == ccsm_pkg::TO_RC_EDGES) begin
                     osc_q       <= ccsm_pkg::OSC_RC;
                     slow_flag_q <= 1'b0;
                     fast_flag_q <= 1'b1;
                  end else begin
                     edge_cnt_q <= edge_cnt_q + 4'h1;
                  end
               end
            end
            default: osc_q <= ccsm_pkg::OSC_SLOW;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         OSC_SEL_SLOW <= 1'b1;
         RC_ENABLE    <= 1'b0;
         SLOW_ENABLE  <= 1'b1;
      end else begin
         OSC_SEL_SLOW <= (osc_q == ccsm_pkg::OSC_SLOW) || (osc_q == ccsm_pkg::OSC_TO_RC);
         RC_ENABLE    <= (osc_q != ccsm_pkg::OSC_SLOW);
         SLOW_ENABLE  <= (osc_q != ccsm_pkg::OSC_RC);
      end
   end

   // ----------------------------------------
   // RC prescaler
   // ----------------------------------------
   logic [3:0] div_cnt_q;
   logic [3:0] div_last;

   always_comb begin
      case (div_code_q)
         3'h1:    div_last = 4'h1;
         3'h2:    div_last = 4'h3;
         3'h3:    div_last = 4'h7;
         3'h4:    div_last = 4'hF;
         default: div_last = 4'h0;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (clr) begin
         div_cnt_q <= 4'h0;
         OSC_TICK  <= 1'b0;
      end else begin
         OSC_TICK <= 1'b0;
         if (rc_rise && osc_q == ccsm_pkg::OSC_RC) begin
            if (div_cnt_q >= div_last) begin
               div_cnt_q <= 4'h0;
               OSC_TICK  <= 1'b1;
            end else begin
               div_cnt_q <= div_cnt_q + 4'h1;
            end
         end
      end
   end

   // ----------------------------------------
   // Reset sequencer
   // ----------------------------------------
   logic       ext_src;
   logic       int_src;
   logic       any_src;
   logic       drive_act_q;
   logic       delay_slow_q;
   logic [9:0] cnt_q;
   logic [9:0] wdg_cnt_q;
   logic [9:0] delay_len;
   logic [2:0] rel_q;

   // Pin sampled only once our own drive has left the synchroniser
   always_ff @(posedge MCLK) begin
      if (!RST_N || !RESET_PIN_OE_N) begin
         rel_q <= 3'h0;
      end else if (rel_q != ccsm_pkg::PIN_SETTLE_CYC) begin
         rel_q <= rel_q + 3'h1;
      end
   end

   assign ext_src = pins.pin_low && !port_mode &&
                    (rel_q == ccsm_pkg::PIN_SETTLE_CYC);
   assign int_src = pins.low_supply || WDG_UNDERFLOW || ILLEGAL_OPCODE;
   assign any_src = ext_src || int_src;
   assign delay_len = delay_slow_q ? ccsm_pkg::DELAY_SLOW_CYC
                                   : ccsm_pkg::DELAY_RC_CYC;

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         wdg_cnt_q <= 10'h000;
      end else if (WDG_UNDERFLOW) begin
         wdg_cnt_q <= ccsm_pkg::WDG_PULSE_CYC;
      end else if (wdg_cnt_q != 10'h000) begin
         wdg_cnt_q <= wdg_cnt_q - 10'h001;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         seq_q        <= ccsm_pkg::SEQ_ACTIVE;
         drive_act_q  <= 1'b1;
         delay_slow_q <= OPT_SLOW_START;
         cnt_q        <= 10'h000;
         lsr_flag_q   <= 1'b0;
      end else begin
         case (seq_q)
            ccsm_pkg::SEQ_RUN, ccsm_pkg::SEQ_FETCH: begin
               if (any_src) begin
                  seq_q        <= ccsm_pkg::SEQ_ACTIVE;
                  drive_act_q  <= int_src;
                  delay_slow_q <= HALT_ACTIVE ? OSC_SEL_SLOW : OPT_SLOW_START;
                  lsr_flag_q   <= pins.low_supply;
               end else if (seq_q == ccsm_pkg::SEQ_FETCH) begin
                  if (cnt_q == 10'(ccsm_pkg::FETCH_CYC) - 10'h001) begin
                     seq_q <= ccsm_pkg::SEQ_RUN;
                  end
                  cnt_q <= cnt_q + 10'h001;
               end
            end
            ccsm_pkg::SEQ_ACTIVE: begin
               cnt_q <= 10'h000;
               if (!pins.low_supply && wdg_cnt_q == 10'h000 && !ext_src) begin
                  seq_q <= ccsm_pkg::SEQ_DELAY;
               end
               if (!RESET_PIN_OE_N && !pins.low_supply && wdg_cnt_q == 10'h000) begin
                  seq_q <= ccsm_pkg::SEQ_DELAY;
               end
            end
            ccsm_pkg::SEQ_DELAY: begin
               if (int_src) begin
                  seq_q       <= ccsm_pkg::SEQ_ACTIVE;
                  drive_act_q <= 1'b1;
                  lsr_flag_q  <= pins.low_supply;
               end else if (cnt_q == delay_len - 10'h001) begin
                  seq_q <= ccsm_pkg::SEQ_FETCH;
                  cnt_q <= 10'h000;
               end else begin
                  cnt_q <= cnt_q + 10'h001;
               end
            end
            default: seq_q <= ccsm_pkg::SEQ_ACTIVE;
         endcase
      end
   end

   // ----------------------------------------
   // Pin drive and core outputs
   // ----------------------------------------
   logic drive_low;

   assign drive_low = !port_mode &&
                      ((seq_q == ccsm_pkg::SEQ_DELAY) ||
                       (seq_q == ccsm_pkg::SEQ_ACTIVE && drive_act_q) ||
                       pins.low_supply ||
                       (wdg_cnt_q != 10'h000));

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         RESET_PIN_OUT  <= 1'b0;
         RESET_PIN_OE_N <= 1'b0;
         CORE_RESET_N   <= 1'b0;
         VECTOR_FETCH   <= 1'b0;
         VECTOR_ADDR    <= ccsm_pkg::RESET_VECTOR_ADDR;
         PIN_IS_PORT    <= 1'b0;
      end else begin
         RESET_PIN_OUT  <= 1'b0;
         RESET_PIN_OE_N <= !drive_low;
         CORE_RESET_N   <= (seq_q == ccsm_pkg::SEQ_RUN);
         VECTOR_FETCH   <= (seq_q == ccsm_pkg::SEQ_FETCH) && !any_src;
         VECTOR_ADDR    <= ccsm_pkg::RESET_VECTOR_ADDR;
         PIN_IS_PORT    <= port_mode;
      end
   end

endmodule
`default_nettype wire

// File: ccsm_pkg.sv
// Behaviour
// - Prescaler code divides RC by 2,4,8,16
// - Prescaler register resets to 03h
// - Slow ready flag owned by hardware
// - Fast ready flag owned by hardware
// - Bit 0 selects oscillator, resets 09h
// - To slow: clear fast, three slow edges
// - To RC: nine RC edges, flags swap
// - Pin, low supply, watchdog start reset
// - Illegal opcode also starts reset
// - Pin driven low during delay phase
// - Vector fetched from FFFEh
// - Phases: active, delay, two-cycle fetch
// - Delay 512 RC, 256 slow
// - Delay source from option or pre-halt clock
// - External pin reset caught during halt
// - Low supply drives pin low
// - Watchdog drives pin low minimum pulse
// - Key pair written once per reset
// - Keys 55h/AAh turn pin into port
// - Software cannot restore reset function
// - Internal reset clears both keys
package ccsm_pkg;

   // ----------------------------------------
   // Register indices (word index, byte address is index times 4)
   // ----------------------------------------
   localparam logic [11:0] IDX_MAIN_CLOCK_CTRL  = 12'h038;
   localparam logic [11:0] IDX_RC_TRIM_HIGH     = 12'h039;
   localparam logic [11:0] IDX_INTEGRITY        = 12'h03A;
   localparam logic [11:0] IDX_RC_DIV_THRESH    = 12'h03E;
   localparam logic [11:0] IDX_OSC_SWITCH       = 12'h03F;
   localparam logic [11:0] IDX_PIN_KEY_LOW      = 12'h047;
   localparam logic [11:0] IDX_PIN_KEY_HIGH     = 12'h048;

   // ----------------------------------------
   // Reset values and fields
   // ----------------------------------------
   localparam logic [7:0]  RST_MAIN_CLOCK_CTRL  = 8'h00;
   localparam logic [7:0]  RST_RC_TRIM_HIGH     = 8'hFF;
   localparam logic [1:0]  RST_TRIM_LOW         = 2'h0;
   localparam logic [2:0]  RST_DIV_CODE         = 3'h0;
   localparam logic [1:0]  RST_THRESHOLD        = 2'h3;
   localparam logic [7:0]  RST_PIN_KEY          = 8'h00;
   localparam logic [7:0]  KEY_LOW_PORT         = 8'h55;
   localparam logic [7:0]  KEY_HIGH_PORT        = 8'hAA;
   localparam int          DIV_MSB              = 7;
   localparam int          DIV_LSB              = 5;
   localparam int          SLOW_FLAG_BIT        = 3;
   localparam int          FAST_FLAG_BIT        = 2;
   localparam int          SRC_SEL_BIT          = 0;
   localparam int          LSR_FLAG_BIT         = 2;
   localparam logic [15:0] RESET_VECTOR_ADDR    = 16'hFFFE;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int          CLK_PERIOD_NS        = 20;
   localparam int          WDG_PULSE_NS         = 1000;
   localparam logic [9:0]  WDG_PULSE_CYC        = 10'((WDG_PULSE_NS + CLK_PERIOD_NS - 1)
                                                      / CLK_PERIOD_NS);
   localparam logic [9:0]  DELAY_RC_CYC         = 10'h200;
   localparam logic [9:0]  DELAY_SLOW_CYC       = 10'h100;
   localparam logic [1:0]  FETCH_CYC            = 2'h2;
   localparam logic [3:0]  TO_RC_EDGES          = 4'h8;
   localparam logic [3:0]  TO_SLOW_EDGES        = 4'h3;
   localparam logic [2:0]  PIN_SETTLE_CYC       = 3'h7;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SEQ_RUN,
      SEQ_ACTIVE,
      SEQ_DELAY,
      SEQ_FETCH
   } ccsm_seq_t;

   typedef enum logic [1:0] {
      OSC_RC,
      OSC_TO_SLOW,
      OSC_SLOW,
      OSC_TO_RC
   } ccsm_osc_t;

   typedef struct packed {
      logic pin_low;
      logic low_supply;
      logic rc_clk;
      logic slow_clk;
   } ccsm_pins_t;

endpackage

// File: ccsm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ccsm_sync (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire ccsm_pkg::ccsm_pins_t din,
   output var  ccsm_pkg::ccsm_pins_t dout
);

   // ----------------------------------------
   // Three stages, change taken when 2 and 3 agree
   // ----------------------------------------
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;
   logic [3:0] out_q;

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               s1_q[i]  <= 1'b0;
               s2_q[i]  <= 1'b0;
               s3_q[i]  <= 1'b0;
               out_q[i] <= 1'b0;
            end else begin
               s1_q[i] <= din[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i]) begin
                  out_q[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate

   assign dout = ccsm_pkg::ccsm_pins_t'(out_q);

endmodule
`default_nettype wire

// File: ccsm_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ccsm_partner (
   input  wire logic rc_en,
   input  wire logic slow_en,
   input  wire logic pull_low,
   input  wire logic oe_n,
   input  wire logic pin_out,
   output var  logic rc_clk,
   output var  logic slow_clk,
   output wire logic pin
);
   initial begin
      rc_clk = 1'b0;
      slow_clk = 1'b0;
   end
   // Oscillators stand still while disabled
   always begin
      #40;
      if (rc_en) rc_clk = ~rc_clk;
   end
   always begin
      #140;
      if (slow_en) slow_clk = ~slow_clk;
   end
   // Pull-up unless pulled low outside or by the device
   assign pin = !(pull_low || (!oe_n && !pin_out));
endmodule
`default_nettype wire

// File: ccsm_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ccsm_top_sva (
   input wire logic        MCLK,
   input wire logic        RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        RESET_PIN_OUT,
   input wire logic        RESET_PIN_OE_N,
   input wire logic        LOW_SUPPLY_IN,
   input wire logic        WDG_UNDERFLOW,
   input wire logic        ILLEGAL_OPCODE,
   input wire logic        CORE_RESET_N,
   input wire logic        VECTOR_FETCH,
   input wire logic [15:0] VECTOR_ADDR,
   input wire logic        OSC_TICK,
   input wire logic        OSC_SEL_SLOW,
   input wire logic        PIN_IS_PORT
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   a_fetch_two_cycles: assert property (
      $rose(VECTOR_FETCH) |=> VECTOR_FETCH ##1 !VECTOR_FETCH) else $error("fetch length");
   a_vector_fixed: assert property (
      VECTOR_FETCH |-> VECTOR_ADDR == ccsm_pkg::RESET_VECTOR_ADDR) else $error("vector");
   a_pin_low_delay: assert property (
      $rose(VECTOR_FETCH) |-> $past(RESET_PIN_OE_N) == 1'b0 && RESET_PIN_OUT == 1'b0)
      else $error("pin not low in delay");
   a_wdg_to_reset: assert property (
      WDG_UNDERFLOW && CORE_RESET_N |-> ##2 !CORE_RESET_N) else $error("wdg reset");
   a_wdg_pin_pulse: assert property (
      WDG_UNDERFLOW && CORE_RESET_N && !PIN_IS_PORT |-> ##2 !RESET_PIN_OE_N [*8])
      else $error("wdg pin pulse");
   a_illegal_reset: assert property (
      ILLEGAL_OPCODE && CORE_RESET_N |-> ##2 !CORE_RESET_N) else $error("illegal reset");
   a_low_supply_pin: assert property (
      LOW_SUPPLY_IN [*8] |-> !CORE_RESET_N && !RESET_PIN_OE_N) else $error("low supply");
   a_port_sticky: assert property (
      $fell(PIN_IS_PORT) |-> !CORE_RESET_N) else $error("port lost");
   a_ready_one_wait: assert property (
      PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
   a_err_with_ready: assert property (
      PSLVERR |-> PREADY) else $error("err without ready");
   a_tick_rc_only: assert property (
      OSC_SEL_SLOW |-> !OSC_TICK) else $error("tick on slow clock");
endmodule
bind ccsm_top ccsm_top_sva chk_u (.*);
`default_nettype wire

// File: clock_reset_sequence_manager_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module clock_reset_sequence_manager_tb_top;
   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic        pin, pin_out, pin_oe_n, low_sup, wdg, illegal, halt, opt_slow;
   logic        rc_clk, slow_clk, core_rst_n, vfetch, tick, sel_slow, rc_en, slow_en;
   logic        is_port, pull_low;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [15:0] vaddr;
   int          mismatches, comparisons, cycles, n;
   ccsm_top dut_u (
      .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RESET_PIN_IN(pin), .RESET_PIN_OUT(pin_out), .RESET_PIN_OE_N(pin_oe_n),
      .LOW_SUPPLY_IN(low_sup), .WDG_UNDERFLOW(wdg), .ILLEGAL_OPCODE(illegal),
      .HALT_ACTIVE(halt), .OPT_SLOW_START(opt_slow), .RC_CLK_IN(rc_clk),
      .SLOW_CLK_IN(slow_clk), .CORE_RESET_N(core_rst_n), .VECTOR_FETCH(vfetch),
      .VECTOR_ADDR(vaddr), .OSC_TICK(tick), .OSC_SEL_SLOW(sel_slow), .RC_ENABLE(rc_en),
      .SLOW_ENABLE(slow_en), .PIN_IS_PORT(is_port));
   ccsm_partner far_u (
      .rc_en(rc_en), .slow_en(slow_en), .pull_low(pull_low), .oe_n(pin_oe_n),
      .pin_out(pin_out), .rc_clk(rc_clk), .slow_clk(slow_clk), .pin(pin));
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end
   // --------
   // Tasks
   // --------
   task end_of_test;
      if (mismatches == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk1(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %b seen %b", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      t = 0;
      @(posedge mclk);
      while (pready !== 1'b1 && t < 20) begin
         @(posedge mclk);
         t++;
      end
      if (pready !== 1'b1) mismatches++;
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] i, input logic [7:0] d);
      apb(1'b1, {i[9:0], 2'h0}, {24'h0, d});
   endtask
   task rd(input logic [11:0] i, input string nm, input logic [7:0] e);
      apb(1'b0, {i[9:0], 2'h0}, 32'h0);
      chk32(nm, {24'h0, e}, rdata);
   endtask
   task poll(input logic [11:0] i, input string nm, input logic [7:0] e);
      apb(1'b0, {i[9:0], 2'h0}, 32'h0);
      repeat (100) if (rdata[7:0] !== e) apb(1'b0, {i[9:0], 2'h0}, 32'h0);
      chk32(nm, {24'h0, e}, rdata);
   endtask
   task wait_run(input int lo, input int hi);
      n = 0;
      while (core_rst_n !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      chk1("reset length", 1'b1, n >= lo && n <= hi);
   endtask
   task gap(input logic [2:0] c, input int e);
      wr(ccsm_pkg::IDX_RC_DIV_THRESH, {c, 5'h03});
      rd(ccsm_pkg::IDX_RC_DIV_THRESH, "divider", {c, 5'h03});
      repeat (3) begin
         n = 1;
         @(posedge mclk);
         while (tick !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
         end
      end
      chk32("tick gap", e, n);
   endtask
   // --------
   // Tests
   // --------
   initial begin
      {mclk, rst_n, psel, penable, pwrite, low_sup, wdg, illegal, halt, pull_low} = '0;
      {paddr, pwdata, mismatches, comparisons, cycles} = '0;
      opt_slow = 1'b1;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      wait_run(256, 290);
      rd(ccsm_pkg::IDX_RC_DIV_THRESH, "divider reset", 8'h03);
      rd(ccsm_pkg::IDX_OSC_SWITCH, "osc reset", 8'h09);
      rd(ccsm_pkg::IDX_PIN_KEY_LOW, "key low reset", 8'h00);
      rd(ccsm_pkg::IDX_PIN_KEY_HIGH, "key high reset", 8'h00);
      wr(ccsm_pkg::IDX_OSC_SWITCH, 8'h00);
      rd(ccsm_pkg::IDX_OSC_SWITCH, "osc going rc", 8'h08);
      poll(ccsm_pkg::IDX_OSC_SWITCH, "osc on rc", 8'h04);
      chk1("sel slow", 1'b0, sel_slow);
      chk1("slow osc off", 1'b0, slow_en);
      for (int c = 0; c < 8; c++) gap(c, (c >= 1 && c <= 4) ? 4 << c : 4);
      wr(ccsm_pkg::IDX_RC_DIV_THRESH, 8'h23);
      wr(ccsm_pkg::IDX_OSC_SWITCH, 8'h01);
      rd(ccsm_pkg::IDX_OSC_SWITCH, "osc going slow", 8'h01);
      poll(ccsm_pkg::IDX_OSC_SWITCH, "osc on slow", 8'h09);
      repeat (20) @(posedge mclk);
      chk1("sel slow", 1'b1, sel_slow);
      chk1("rc osc off", 1'b0, rc_en);
      apb(1'b0, 12'h004, 32'h0);
      chk1("unmapped err", 1'b1, err);
      apb(1'b1, 12'h0F9, 32'h0);
      chk1("unaligned err", 1'b1, err);
      wr(ccsm_pkg::IDX_PIN_KEY_LOW, 8'h55);
      wr(ccsm_pkg::IDX_PIN_KEY_HIGH, 8'hAA);
      wr(ccsm_pkg::IDX_PIN_KEY_LOW, 8'h00);
      rd(ccsm_pkg::IDX_PIN_KEY_LOW, "key low once", 8'h55);
      chk1("pin port", 1'b1, is_port);
      pull_low <= 1'b1;
      repeat (10) @(posedge mclk);
      pull_low <= 1'b0;
      chk1("port ignores pin", 1'b1, core_rst_n);
      wdg <= 1'b1;
      @(posedge mclk);
      wdg <= 1'b0;
      repeat (3) @(posedge mclk);
      chk1("wdg pin drive", 1'b0, pin_oe_n);
      wait_run(290, 340);
      rd(ccsm_pkg::IDX_PIN_KEY_LOW, "key low cleared", 8'h00);
      chk1("pin reset again", 1'b0, is_port);
      pull_low <= 1'b1;
      repeat (10) @(posedge mclk);
      chk1("pin reset", 1'b0, core_rst_n);
      pull_low <= 1'b0;
      wait_run(250, 300);
      opt_slow <= 1'b0;
      illegal <= 1'b1;
      @(posedge mclk);
      illegal <= 1'b0;
      repeat (100) @(posedge mclk);
      low_sup <= 1'b1;
      repeat (20) @(posedge mclk);
      chk1("low supply drive", 1'b0, pin_oe_n);
      low_sup <= 1'b0;
      wait_run(510, 540);
      end_of_test();
   end
endmodule
`default_nettype wire
